// ### core/cgu_consts.svh
/*
 * Register offsets, field positions, reset values and polynomials of the CRC generator.
 * Assumes nothing of its surroundings; included by the core only.
 */
`ifndef CGU_CONSTS_SVH
`define CGU_CONSTS_SVH

`define CGU_OFS_CONTROL    3'h0
`define CGU_OFS_STATUS     3'h2
`define CGU_OFS_BYTE_INPUT 3'h3
`define CGU_OFS_CHECKSUM_BYTE0  3'h4

`define CGU_CTRL_SRC_LSB   0
`define CGU_CTRL_WIDE_BIT  5
`define CGU_CTRL_CMD_LSB   6
`define CGU_STAT_BUSY_BIT  0
`define CGU_STAT_ZERO_BIT  1

`define CGU_RESET_BYTE     8'h00
`define CGU_POLY16         16'h1021
`define CGU_POLY32         32'h04c11db7
`define CGU_CMD_ZEROS      2'h2
`define CGU_CMD_ONES       2'h3

`endif

// ### core/cgu_pkg.sv
/*
 * Types shared by the CRC generator core.
 * Assumes the constants header is on the include path.
 */
package cgu_pkg;

    typedef enum logic [3:0] {
        CGU_SRC_DISABLE = 4'h0,
        CGU_SRC_REGS    = 4'h1,
        CGU_SRC_FLASH   = 4'h2
    } cgu_src_t;

    // Register access from the processor side.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } cgu_reg_req_t;

    // Byte stream from the memory controller.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } cgu_byte_t;

endpackage

// ### core/cgu_crc_generator.sv
/*
 * Byte-wide CRC generator with a register port and a flash byte stream.
 * Assumes one 10 MHz clock, inputs synchronous to it, and a memory controller that
 * raises flash_done_i for one cycle once it has delivered its last byte.
 */
// Function
// - supports polynomials 0x1021 and 0x04C11DB7
// - four-bit source selects off, registers, flash
// - register source follows width bit; flash forces wide
// - written byte folded, checksum ready next cycle
// - one byte per cycle, continuous, whole bytes
// - reset command reads zero; 10 zeros, 11 ones
// - registers reset one cycle after command bit
// - width bit locked while busy
// - source locked until completion or reset
// - busy while source in use; cleared per source
// - zero flag at completion; cleared on new source
// - wide residue reads 0x2144df1c or zero
// - wide and idle reads reversed complemented value
// - flash source reads zero while busy
// - checksum writable only while disabled
// - four bytes at ascending offsets
// - controller starts run and signals completion
`timescale 1ns/1ps
`include "cgu_consts.svh"

module cgu_crc_generator #(
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,
    // Register port
    input  wire cgu_pkg::cgu_reg_req_t reg_req_i,
    output logic [7:0]                 reg_rdata_o,
    // Flash byte stream
    input  wire cgu_pkg::cgu_byte_t    flash_byte_i,
    output logic                       flash_ready_o,
    input  wire logic                  flash_done_i
);
    import cgu_pkg::*;

    cgu_src_t    src_q;
    logic        wide_q;
    logic        busy_q;
    logic        zero_q;
    logic [31:0] crc_q;
    logic [1:0]  cmd_q;
    logic [7:0]  rdata_q;
    logic [7:0]  buf_q [BUF_DEPTH];
    logic [1:0]  cnt_q;
    logic        wr_ptr_q;
    logic        rd_ptr_q;
    logic        done_pend_q;

    logic ctrl_wr;
    logic stat_wr;
    logic in_wr;
    logic wide_eff;
    logic buf_push;
    logic buf_pop;
    logic buf_full;
    logic buf_empty;
    logic [7:0] buf_head;
    logic run_done;
    logic [31:0] crc_next;
    logic [31:0] crc_view;

    assign ctrl_wr = reg_req_i.wr && reg_req_i.addr == `CGU_OFS_CONTROL;
    assign stat_wr = reg_req_i.wr && reg_req_i.addr == `CGU_OFS_STATUS;
    assign in_wr   = reg_req_i.wr && reg_req_i.addr == `CGU_OFS_BYTE_INPUT;

    // Flash always runs the wide polynomial.
    assign wide_eff = (src_q == CGU_SRC_FLASH) ? 1'b1 : wide_q;

    // Fold one byte. Wide feeds lsb first into the plain register, narrow msb first.
    function automatic logic [31:0] cgu_fold(input logic [31:0] crc, input logic [7:0] b,
                                             input logic wide);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            if (wide) begin
                c = (c[31] ^ b[i]) ? ({c[30:0], 1'b0} ^ `CGU_POLY32) : {c[30:0], 1'b0};
            end else begin
                c[15:0] = (c[15] ^ b[7-i]) ? ({c[14:0], 1'b0} ^ `CGU_POLY16)
                                           : {c[14:0], 1'b0};
                c[31:16] = 16'h0000;
            end
        end
        return c;
    endfunction

    // Two-entry buffer on the flash path; a stall of the fold never drops a byte.
    assign buf_full      = cnt_q == 2'(BUF_DEPTH);
    assign buf_empty     = cnt_q == 2'h0;
    assign flash_ready_o = !buf_full && src_q == CGU_SRC_FLASH && busy_q;
    assign buf_push      = flash_byte_i.valid && flash_ready_o;
    // The register port has priority; a flash byte waits in the buffer meanwhile.
    assign buf_pop       = !buf_empty && !in_wr;
    assign buf_head      = buf_q[rd_ptr_q];
    // Completion only after the buffer has drained.
    assign run_done      = src_q == CGU_SRC_FLASH && busy_q && buf_empty
                           && (flash_done_i || done_pend_q);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || cmd_q[1]) begin
            cnt_q    <= 2'h0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (buf_push) begin
                buf_q[wr_ptr_q] <= flash_byte_i.data;
                wr_ptr_q        <= !wr_ptr_q;
            end
            if (buf_pop) begin
                rd_ptr_q <= !rd_ptr_q;
            end
            cnt_q <= 2'(cnt_q + {1'b0, buf_push} - {1'b0, buf_pop});
        end
    end

    // A one-cycle done pulse may arrive while a byte still waits in the buffer; keep it.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || cmd_q[1] || run_done) begin
            done_pend_q <= 1'b0;
        end else if (flash_done_i && src_q == CGU_SRC_FLASH && busy_q) begin
            done_pend_q <= 1'b1;
        end
    end

    // Reset command is held one cycle, then acts.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cmd_q <= 2'h0;
        end else if (ctrl_wr) begin
            cmd_q <= reg_req_i.wdata[`CGU_CTRL_CMD_LSB +: 2];
        end else begin
            cmd_q <= 2'h0;
        end
    end

    // Source, width and busy.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || cmd_q[1]) begin
            src_q  <= CGU_SRC_DISABLE;
            wide_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (ctrl_wr && !busy_q) begin
                wide_q <= reg_req_i.wdata[`CGU_CTRL_WIDE_BIT];
                case (reg_req_i.wdata[`CGU_CTRL_SRC_LSB +: 4])
                    4'h0: begin
                        src_q  <= CGU_SRC_DISABLE;
                        busy_q <= 1'b0;
                    end
                    4'h1: begin
                        src_q  <= CGU_SRC_REGS;
                        busy_q <= 1'b1;
                    end
                    4'h2: begin
                        src_q  <= CGU_SRC_FLASH;
                        busy_q <= 1'b1;
                    end
                    default: begin
                        src_q  <= src_q;
                    end
                endcase
            end
            // Source stays locked while busy.
            if (stat_wr && reg_req_i.wdata[`CGU_STAT_BUSY_BIT] && src_q == CGU_SRC_REGS
                && busy_q) begin
                busy_q <= 1'b0;
            end
            if (run_done) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_comb begin
        crc_next = crc_q;
        if (in_wr && src_q == CGU_SRC_REGS && busy_q) begin
            crc_next = cgu_fold(crc_q, reg_req_i.wdata, wide_eff);
        end else if (buf_pop && src_q == CGU_SRC_FLASH) begin
            crc_next = cgu_fold(crc_q, buf_head, 1'b1);
        end
    end

    // Running checksum; a byte a cycle, result visible the cycle after.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            crc_q <= 32'h0000_0000;
        end else if (cmd_q == `CGU_CMD_ZEROS) begin
            crc_q <= 32'h0000_0000;
        end else if (cmd_q == `CGU_CMD_ONES) begin
            crc_q <= 32'hffff_ffff;
        end else if (reg_req_i.wr && reg_req_i.addr[2] && src_q == CGU_SRC_DISABLE) begin
            crc_q[8*reg_req_i.addr[1:0] +: 8] <= reg_req_i.wdata;
        end else begin
            crc_q <= crc_next;
        end
    end

    // Zero flag: at completion, cleared on new source selection.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || cmd_q[1]) begin
            zero_q <= 1'b0;
        end else if (run_done) begin
            zero_q <= crc_q == 32'h0000_0000;
        end else if (stat_wr && reg_req_i.wdata[`CGU_STAT_BUSY_BIT] && src_q == CGU_SRC_REGS
                     && busy_q) begin
            zero_q <= wide_q ? (crc_q == 32'h0000_0000) : (crc_q[15:0] == 16'h0000);
        end else if (ctrl_wr && !busy_q
                     && (reg_req_i.wdata[3:0] == 4'h1 || reg_req_i.wdata[3:0] == 4'h2)) begin
            zero_q <= 1'b0;
        end
    end

    // Read view: zero while flash busy, raw while register-source busy or narrow, reversed and complemented when wide and idle.
    always_comb begin
        crc_view = crc_q;
        if (wide_eff && !busy_q) begin
            crc_view = ~{<<{crc_q}};
        end
        if (src_q == CGU_SRC_FLASH && busy_q) begin
            crc_view = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_q <= `CGU_RESET_BYTE;
        end else if (reg_req_i.rd) begin
            if (reg_req_i.addr == `CGU_OFS_CONTROL) begin
                rdata_q <= {2'b00, wide_q, 1'b0, src_q};
            end else if (reg_req_i.addr == `CGU_OFS_STATUS) begin
                rdata_q <= {6'h00, zero_q, busy_q};
            end else if (reg_req_i.addr[2]) begin
                rdata_q <= crc_view[8*reg_req_i.addr[1:0] +: 8];
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign reg_rdata_o = rdata_q;

    // A register-source run ends when software writes one to the busy bit.
    property p_busy_clear_io;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (stat_wr && reg_req_i.wdata[0] && src_q == CGU_SRC_REGS && busy_q && !cmd_q[1])
            |=> !busy_q;
    endproperty
    a_busy_clear_io: assert property (p_busy_clear_io) else $error("busy not cleared");

    property p_flash_zero_read;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_req_i.rd && reg_req_i.addr[2] && src_q == CGU_SRC_FLASH && busy_q)
            |=> reg_rdata_o == 8'h00;
    endproperty
    a_flash_zero_read: assert property (p_flash_zero_read) else $error("flash read not zero");

    property p_cmd_ones;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (ctrl_wr && reg_req_i.wdata[7:6] == 2'h3) |=> ##1 crc_q == 32'hffff_ffff;
    endproperty
    a_cmd_ones: assert property (p_cmd_ones) else $error("ones reset missed");

    property p_width_locked;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (busy_q && !cmd_q[1]) |=> $stable(wide_q);
    endproperty
    a_width_locked: assert property (p_width_locked) else $error("width changed busy");

    property p_ignored_byte;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (in_wr && !(src_q == CGU_SRC_REGS && busy_q) && cmd_q == 2'h0)
            |=> $stable(crc_q);
    endproperty
    a_ignored_byte: assert property (p_ignored_byte) else $error("byte not ignored");

    property p_flash_wide;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (src_q == CGU_SRC_FLASH && buf_pop && !wide_q && cmd_q == 2'h0)
            |=> crc_q == cgu_fold($past(crc_q), $past(buf_head), 1'b1);
    endproperty
    a_flash_wide: assert property (p_flash_wide) else $error("flash not wide");

    property p_zero_on_select;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (ctrl_wr && !busy_q && reg_req_i.wdata[3:0] == 4'h1 && !cmd_q[1]) |=> !zero_q && busy_q;
    endproperty
    a_zero_on_select: assert property (p_zero_on_select) else $error("zero not cleared");

    property p_src_lock;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (busy_q && !cmd_q[1]) |=> src_q == $past(src_q);
    endproperty
    a_src_lock: assert property (p_src_lock) else $error("source changed busy");

    property p_cmd_reads_zero;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_req_i.rd && reg_req_i.addr == `CGU_OFS_CONTROL)
            |=> reg_rdata_o[7:6] == 2'h0;
    endproperty
    a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command bits read");

    property p_cmd_zeros;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (ctrl_wr && reg_req_i.wdata[7:6] == 2'h2)
            |=> ##1 crc_q == 32'h0000_0000;
    endproperty
    a_cmd_zeros: assert property (p_cmd_zeros) else $error("zeros reset missed");

    property p_sum_write_locked;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_req_i.wr && reg_req_i.addr[2] && src_q != CGU_SRC_DISABLE && cmd_q == 2'h0
            && !buf_pop) |=> $stable(crc_q);
    endproperty
    a_sum_write_locked: assert property (p_sum_write_locked) else $error("sum written");

    property p_done_after_drain;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (src_q == CGU_SRC_FLASH && busy_q && flash_done_i && cnt_q == 2'h1 && !in_wr
            && !buf_push && !cmd_q[1]) |=> ##1 !busy_q;
    endproperty
    a_done_after_drain: assert property (p_done_after_drain) else $error("done pulse lost");

    property p_status_reserved;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_req_i.rd && reg_req_i.addr == `CGU_OFS_STATUS)
            |=> reg_rdata_o[7:2] == 6'h00;
    endproperty
    a_status_reserved: assert property (p_status_reserved) else $error("status bits set");

    property p_disabled_quiet;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (src_q == CGU_SRC_DISABLE)
            |-> !busy_q && !flash_ready_o;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled but active");

endmodule

// ### bench/cgu_flash_model.sv
/*
 * Memory controller model that streams flash bytes into the CRC generator.
 * Assumes the bench calls run() while the flash source is selected.
 */
`timescale 1ns/1ps
module cgu_flash_model (
    // Clock
    input  wire logic           clk_sys_i,
    // Byte stream
    input  wire logic           ready_i,
    output cgu_pkg::cgu_byte_t  byte_o,
    output logic                done_o
);
    import cgu_pkg::*;
    initial begin
        byte_o = '0;
        done_o = 1'b0;
    end
    // Every other byte stalls; a released data line shows the inverse so stale use shows.
    task automatic run(input logic [7:0] q[$], input int gap);
        foreach (q[i]) begin
            @(negedge clk_sys_i);
            if (gap > 0 && i % 2 == 1) begin
                byte_o = '{1'b0, ~byte_o.data};
                repeat (gap) @(negedge clk_sys_i);
            end
            byte_o = '{1'b1, q[i]};
            do @(posedge clk_sys_i); while (ready_i !== 1'b1);
        end
        @(negedge clk_sys_i);
        byte_o = '{1'b0, ~byte_o.data};
        done_o = 1'b1;
        @(negedge clk_sys_i);
        done_o = 1'b0;
    endtask
endmodule

// ### bench/testbench.sv
/*
 * Self-checking bench for the CRC generator, register port and flash stream.
 * Assumes the package and the flash model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    import cgu_pkg::*;
    logic         clk_sys_i = 1'b0;
    logic         rst_n_i   = 1'b0;
    cgu_reg_req_t req       = '0;
    logic [7:0]   rdata;
    cgu_byte_t    fbyte;
    logic         fready;
    logic         fdone;
    int           err_count = 0;
    int           tests_run = 0;
    int           cycles    = 0;
    logic [31:0]  seed      = 32'hed48;
    logic [31:0]  v;
    logic [31:0]  r;
    logic [15:0]  c;
    logic [7:0]   b;
    logic [7:0]   q[$];

    always #50 clk_sys_i = ~clk_sys_i;

    cgu_crc_generator i_cgu_crc_generator (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .flash_byte_i(fbyte), .flash_ready_o(fready), .flash_done_i(fdone));
    cgu_flash_model i_cgu_flash_model (
        .clk_sys_i(clk_sys_i), .ready_i(fready), .byte_o(fbyte), .done_o(fdone));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] f16(logic [15:0] s, logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            s = {s[14:0], 1'b0} ^ ((s[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return s;
    endfunction
    function automatic logic [31:0] f32(logic [31:0] s, logic [7:0] d);
        for (int i = 0; i < 8; i++)
            s = (s >> 1) ^ ((s[0] ^ d[i]) ? 32'hedb88320 : 32'h00000000);
        return s;
    endfunction

    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(negedge clk_sys_i);
        req = '{1'b1, 1'b0, a, d};
    endtask
    task automatic rd(logic [2:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_sys_i);
        req = '0;
        d = rdata;
    endtask
    task automatic chk(logic [2:0] a, logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask
    task automatic rd32(output logic [31:0] x);
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            rd(3'(4 + i), d);
            x[8*i +: 8] = d;
        end
    endtask
    // A soft reset eats any control write of the next cycle, so one edge passes idle.
    task automatic settle();
        @(negedge clk_sys_i);
        req = '0;
    endtask
    task automatic wrap_up();
        if (err_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        for (int a = 0; a < 8; a++)
            if (a != 3) chk(3'(a), 8'h00);
        wr(0, 8'h03);
        chk(0, 8'h00);
        // Narrow run from a random start, closed by its own remainder.
        c = 16'(rnd());
        wr(4, c[7:0]);
        wr(5, c[15:8]);
        wr(0, 8'h01);
        wr(4, 8'h5a);
        wr(0, 8'h21);
        q = {};
        repeat (6) q.push_back(8'(rnd()));
        foreach (q[i]) wr(3, q[i]);
        foreach (q[i]) c = f16(c, q[i]);
        chk(4, c[7:0]);
        chk(5, c[15:8]);
        chk(2, 8'h01);
        chk(0, 8'h01);
        wr(3, c[15:8]);
        wr(3, c[7:0]);
        wr(2, 8'h01);
        chk(2, 8'h02);
        wr(3, 8'hff);
        chk(4, 8'h00);
        wr(0, 8'h01);
        chk(2, 8'h01);
        wr(2, 8'h01);
        wr(0, 8'h00);
        wr(4, 8'h3c);
        wr(0, 8'h40);
        chk(4, 8'h3c);
        wr(0, 8'h80);
        settle();
        chk(4, 8'h00);
        // Wide run with its own checksum appended little end first.
        wr(0, 8'hc0);
        settle();
        wr(0, 8'h21);
        r = '1;
        q = {};
        repeat (5) begin
            q.push_back(8'(rnd()));
            r = f32(r, q[$]);
        end
        v = ~r;
        for (int i = 0; i < 4; i++) q.push_back(v[8*i +: 8]);
        foreach (q[i]) wr(3, q[i]);
        wr(2, 8'h01);
        rd32(v);
        `CHK(v, 32'h2144df1c)
        // Same run with the complemented checksum appended: the remainder is zero.
        wr(0, 8'hc0);
        settle();
        wr(0, 8'h21);
        for (int i = 0; i < 4; i++) q[5 + i] = r[8*i +: 8];
        foreach (q[i]) wr(3, q[i]);
        rd32(v);
        `CHK(v, 32'h0000_0000)
        wr(2, 8'h01);
        chk(2, 8'h02);
        // Flash run: wide forced, reads hidden while busy, source locked.
        wr(0, 8'hc0);
        settle();
        wr(0, 8'h02);
        r = '1;
        q = {};
        repeat (8) begin
            q.push_back(8'(rnd()));
            r = f32(r, q[$]);
        end
        fork
            i_cgu_flash_model.run(q, 2);
            begin
                chk(4, 8'h00);
                chk(2, 8'h01);
                wr(0, 8'h01);
                wr(3, 8'h77);
                rd(0, b);
                `CHK(b[3:0], 4'h2)
            end
        join
        b = 8'h01;
        for (int k = 0; k < 40 && b[0] !== 1'b0; k++) rd(2, b);
        `CHK(b, 8'h00)
        rd32(v);
        `CHK(v, ~r)
        wrap_up();
    end
endmodule
